// ==== rtl/smw_top.sv ====
// static memory waveform generator: register slave and per chip select waveform engine
`timescale 1ns/1ps
module smw_top (
  input  wire logic                      clk_i,
  input  wire logic                      rst_b_i,
  // ahb-lite register slave
  input  wire logic                      hsel_i,
  input  wire logic [31:0]               haddr_i,
  input  wire logic [1:0]                htrans_i,
  input  wire logic                      hwrite_i,
  input  wire logic [2:0]                hsize_i,
  input  wire logic [31:0]               hwdata_i,
  input  wire logic                      hready_i,
  output logic      [31:0]               hrdata_o,
  output logic                           hreadyout_o,
  output logic                           hresp_o,
  // access port from the on-chip master
  input  wire logic                      req_valid_i,
  input  wire smw_pkg::smw_req_t         req_i,
  output logic                           req_ready_o,
  output logic                           rsp_valid_o,
  output logic      [7:0]                rsp_data_o,
  // external memory
  output smw_pkg::smw_pins_t             pins_o,
  input  wire logic [7:0]                data_i
);

  // decoded effective counts
  // the top bits of each field add a large step, so short fields still reach slow parts
  // every result fits ten bits: the longest cycle field decodes to 895
  function automatic logic [9:0] eff_setup(input logic [5:0] f);
    eff_setup = {2'h0, f[5], 2'h0, f[4:0]};
  endfunction
  function automatic logic [9:0] eff_pulse(input logic [6:0] f);
    eff_pulse = {1'b0, f[6], 2'h0, f[5:0]};
  endfunction
  function automatic logic [9:0] eff_cycle(input logic [8:0] f);
    eff_cycle = {f[8:7], 1'b0, f[6:0]};
  endfunction

  // reset release through two flops
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // ---------------- register slave ----------------
  logic [31:0] setup_q [smw_pkg::NUM_CS];
  logic [31:0] pulse_q [smw_pkg::NUM_CS];
  logic [31:0] cycle_q [smw_pkg::NUM_CS];
  logic [31:0] mode_q  [smw_pkg::NUM_CS];
  logic        prot_en_q;
  logic        viol_q;
  logic [7:0]  viol_src_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] rdata_q;
  logic        acc;
  logic        rd_acc;
  logic        wr_prot_reg;
  logic        prot_hit;
  logic [1:0]  wr_cs;
  logic [31:0] rd_val;

  assign acc         = hsel_i && hready_i && htrans_i[1];
  assign rd_acc      = acc && !hwrite_i;
  assign wr_prot_reg = wr_pend_q && (wr_addr_q < smw_pkg::CS_BLOCK_END);
  assign prot_hit    = wr_prot_reg && prot_en_q;
  assign wr_cs       = wr_addr_q[5:4];
  assign hreadyout_o = 1'b1;                                          // zero wait states
  assign hresp_o     = 1'b0;
  assign hrdata_o    = rdata_q;

  // address phase capture; write lands in the data phase
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= acc && hwrite_i;
      wr_addr_q <= haddr_i[7:0];
    end
  end

  // read mux, sampled at the address phase so data comes from a flop
  always_comb begin
    rd_val = 32'h00000000;
    if (haddr_i[7:0] < smw_pkg::CS_BLOCK_END) begin
      unique case (haddr_i[3:0])
        smw_pkg::OFS_SETUP[3:0]: rd_val = setup_q[haddr_i[5:4]];
        smw_pkg::OFS_PULSE[3:0]: rd_val = pulse_q[haddr_i[5:4]];
        smw_pkg::OFS_CYCLE[3:0]: rd_val = cycle_q[haddr_i[5:4]];
        smw_pkg::OFS_MODE[3:0]:  rd_val = mode_q[haddr_i[5:4]];
        default:                 rd_val = 32'h00000000;
      endcase
    end else if (haddr_i[7:0] == smw_pkg::OFS_PROT_MODE) begin
      rd_val[smw_pkg::POS_PROT_EN] = prot_en_q;
    end else if (haddr_i[7:0] == smw_pkg::OFS_PROT_STATUS) begin
      rd_val[smw_pkg::POS_PROT_FLAG] = viol_q;
      rd_val[smw_pkg::POS_PROT_SRC +: 8] = viol_src_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h00000000;
    end else if (rd_acc) begin
      rdata_q <= rd_val;
    end
  end

  // per chip select timing registers, loop over selects
  for (genvar g = 0; g < smw_pkg::NUM_CS; g++) begin : g_cs_regs
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        setup_q[g] <= smw_pkg::RST_SETUP;
        pulse_q[g] <= smw_pkg::RST_PULSE;
        cycle_q[g] <= smw_pkg::RST_CYCLE;
        mode_q[g]  <= smw_pkg::RST_MODE;
      end else if (wr_prot_reg && !prot_en_q && wr_cs == 2'(g)) begin
        unique case (wr_addr_q[3:0])
          smw_pkg::OFS_SETUP[3:0]: setup_q[g] <= hwdata_i & 32'h3f3f3f3f;
          smw_pkg::OFS_PULSE[3:0]: pulse_q[g] <= hwdata_i & 32'h7f7f7f7f;
          smw_pkg::OFS_CYCLE[3:0]: cycle_q[g] <= hwdata_i & 32'h01ff01ff;
          smw_pkg::OFS_MODE[3:0]:  mode_q[g]  <= hwdata_i & 32'h00000003;
          default: ;
        endcase
      end
    end
  end

  // protection enable, not itself protected so software can always lift it
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prot_en_q <= 1'b0;
    end else if (wr_pend_q && wr_addr_q == smw_pkg::OFS_PROT_MODE) begin
      prot_en_q <= hwdata_i[smw_pkg::POS_PROT_EN];
    end
  end

  // violation flag: a new violation wins over the read-to-clear
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      viol_q     <= 1'b0;
      viol_src_q <= 8'h00;
    end else if (prot_hit) begin
      viol_q     <= 1'b1;
      viol_src_q <= wr_addr_q;
    end else if (rd_acc && haddr_i[7:0] == smw_pkg::OFS_PROT_STATUS) begin
      viol_q     <= 1'b0;
    end
  end

  // ---------------- waveform engine ----------------
  logic              busy_q;
  logic [9:0]        cnt_q;
  smw_pkg::smw_req_t cur_q;
  logic              start;
  logic              last;
  logic              nb;
  logic [9:0]        nc;
  smw_pkg::smw_req_t nr;
  logic [9:0]        cur_cyc;
  logic [9:0]        cur_rd_end;
  logic              cap;
  logic [9:0]        s_str;
  logic [9:0]        p_str;
  logic [9:0]        s_cs;
  logic [9:0]        p_cs;
  logic [9:0]        n_cyc;
  logic              str_lo;
  logic              cs_lo;
  logic              oe;
  smw_pkg::smw_pins_t pins_q;

  // end of cycle and capture point of the access in flight
  always_comb begin
    logic [1:0] c;
    c = cur_q.cs;
    if (cur_q.write) begin
      cur_cyc = eff_cycle(cycle_q[c][smw_pkg::POS_WR_CYCLE +: 9]);
    end else begin
      cur_cyc = eff_cycle(cycle_q[c][smw_pkg::POS_RD_CYCLE +: 9]);
    end
    // mode bit alone chooses; the two waveforms are never compared
    if (mode_q[c][smw_pkg::POS_READ_MODE]) begin
      cur_rd_end = eff_setup(setup_q[c][smw_pkg::POS_RD_STROBE +: 6])
                 + eff_pulse(pulse_q[c][smw_pkg::POS_RD_STROBE +: 7]);
    end else begin
      cur_rd_end = eff_setup(setup_q[c][smw_pkg::POS_CS_READ +: 6])
                 + eff_pulse(pulse_q[c][smw_pkg::POS_CS_READ +: 7]);
    end
  end

  assign last        = busy_q && (cnt_q + 10'h001 >= cur_cyc);
  assign req_ready_o = !busy_q || last;
  assign start       = req_valid_i && req_ready_o;
  // the edge leaving the last low cycle is the one that raises the strobe, or the select for select-controlled reads
  assign cap         = busy_q && !cur_q.write && (cnt_q + 10'h001 == cur_rd_end);

  // next sequencing state
  always_comb begin
    if (start) begin
      nb = 1'b1;
      nc = 10'h000;
      nr = req_i;
    end else if (last) begin
      nb = 1'b0;
      nc = 10'h000;
      nr = cur_q;
    end else begin
      nb = busy_q;
      nc = busy_q ? cnt_q + 10'h001 : 10'h000;
      nr = cur_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q  <= 10'h000;
      cur_q  <= '0;
    end else begin
      busy_q <= nb;
      cnt_q  <= nc;
      cur_q  <= nr;
    end
  end

  // per-select timings for the next cycle; hold is whatever the cycle leaves
  always_comb begin
    logic [1:0] c;
    c = nr.cs;
    if (nr.write) begin
      s_str = eff_setup(setup_q[c][smw_pkg::POS_WR_STROBE +: 6]);
      p_str = eff_pulse(pulse_q[c][smw_pkg::POS_WR_STROBE +: 7]);
      s_cs  = eff_setup(setup_q[c][smw_pkg::POS_CS_WRITE +: 6]);
      p_cs  = eff_pulse(pulse_q[c][smw_pkg::POS_CS_WRITE +: 7]);
      n_cyc = eff_cycle(cycle_q[c][smw_pkg::POS_WR_CYCLE +: 9]);
    end else begin
      s_str = eff_setup(setup_q[c][smw_pkg::POS_RD_STROBE +: 6]);
      p_str = eff_pulse(pulse_q[c][smw_pkg::POS_RD_STROBE +: 7]);
      s_cs  = eff_setup(setup_q[c][smw_pkg::POS_CS_READ +: 6]);
      p_cs  = eff_pulse(pulse_q[c][smw_pkg::POS_CS_READ +: 7]);
      n_cyc = eff_cycle(cycle_q[c][smw_pkg::POS_RD_CYCLE +: 9]);
    end
    // low from setup until setup plus pulse; zero setup/hold gives no gap
    str_lo = nb && (nc >= s_str) && (nc < s_str + p_str);
    cs_lo  = nb && (nc >= s_cs) && (nc < s_cs + p_cs);
    // drivers on from the controlling setup to the cycle end
    if (mode_q[c][smw_pkg::POS_WRITE_MODE]) begin
      oe = nb && nr.write && (nc >= s_str) && (nc < n_cyc);
    end else begin
      oe = nb && nr.write && (nc >= s_cs) && (nc < n_cyc);
    end
  end

  // pins come from flops so the memory sees no decode glitches
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pins_q.addr           <= '0;
      pins_q.chip_select_n  <= '1;
      pins_q.read_strobe_n  <= 1'b1;
      pins_q.write_strobe_n <= 1'b1;
      pins_q.dout           <= '0;
      pins_q.data_oe_b      <= 1'b1;
    end else begin
      if (nb) begin
        pins_q.addr <= nr.addr;
        pins_q.dout <= nr.wdata;
      end
      for (int i = 0; i < smw_pkg::NUM_CS; i++) begin
        pins_q.chip_select_n[i] <= !(cs_lo && nr.cs == i[1:0]);
      end
      pins_q.read_strobe_n  <= !(str_lo && !nr.write);
      pins_q.write_strobe_n <= !(str_lo && nr.write);
      pins_q.data_oe_b      <= !oe;
    end
  end
  assign pins_o = pins_q;

  // read capture straight off the bus at the rising-edge clock
  // no synchroniser: the part holds data across this edge, and extra flops would
  // sample it after the strobe has already released the bus
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= 8'h00;
    end else begin
      rsp_valid_o <= cap;
      if (cap) begin
        rsp_data_o <= data_i;
      end
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_prot_write;
    wr_prot_reg && prot_en_q;
  endsequence
  sequence s_flag_up;
    viol_q && viol_src_q == $past(wr_addr_q);
  endsequence

  a_prot_flag_set: assert property (s_prot_write |=> s_flag_up)
    else $error("protected write did not raise violation");
  a_prot_discard: assert property (
    (prot_en_q && wr_pend_q && wr_addr_q == smw_pkg::OFS_SETUP) |=> $stable(setup_q[0]))
    else $error("protected register changed");
  a_status_clear: assert property (
    (rd_acc && haddr_i[7:0] == smw_pkg::OFS_PROT_STATUS && !prot_hit) |=> !viol_q)
    else $error("status read did not clear flag");
  a_read_no_drive: assert property (
    (busy_q && !cur_q.write) |-> pins_q.data_oe_b)
    else $error("data driven during read");
  a_idle_pins: assert property (
    !busy_q |-> (pins_q.read_strobe_n && pins_q.write_strobe_n && &pins_q.chip_select_n))
    else $error("strobe active while idle");
  a_capture_data: assert property (
    cap |=> (rsp_valid_o && rsp_data_o == $past(data_i)))
    else $error("read data not captured");
  a_addr_stable: assert property (
    (busy_q && !last) |=> $stable(pins_q.addr))
    else $error("address moved inside a cycle");
  a_one_select: assert property (
    $countones(~pins_q.chip_select_n) <= 1)
    else $error("more than one chip select low");
  a_cycle_end: assert property (
    (busy_q && !start && last) |=> !busy_q)
    else $error("cycle overran its length");
  a_rd_cap_edge: assert property (
    (cap && mode_q[cur_q.cs][smw_pkg::POS_READ_MODE] && !last) |=> pins_q.read_strobe_n)
    else $error("capture not on strobe rising edge");

  // a discarded write must leave every timing and mode word of select 3 untouched
  a_prot_keep_all: assert property (
    prot_hit |=> ($stable(setup_q[3]) && $stable(pulse_q[3])
      && $stable(cycle_q[3]) && $stable(mode_q[3])))
    else $error("protected select registers changed");
  // select-controlled reads capture on the edge that raises the select
  a_cs_cap_edge: assert property (
    (cap && !mode_q[cur_q.cs][smw_pkg::POS_READ_MODE] && !last)
      |=> pins_q.chip_select_n[cur_q.cs])
    else $error("capture not on select rising edge");
  // strobe-controlled writes drive the bus whenever the write strobe is low
  a_wr_drive_str: assert property (
    (busy_q && cur_q.write && mode_q[cur_q.cs][smw_pkg::POS_WRITE_MODE]
      && !pins_q.write_strobe_n) |-> !pins_q.data_oe_b)
    else $error("data not driven under write strobe");
  // select-controlled writes drive the bus whenever the select is low
  a_wr_drive_cs: assert property (
    (busy_q && cur_q.write && !mode_q[cur_q.cs][smw_pkg::POS_WRITE_MODE]
      && !pins_q.chip_select_n[cur_q.cs]) |-> !pins_q.data_oe_b)
    else $error("data not driven under chip select");
  // drivers let go once the write cycle is over and nothing follows
  a_wr_drive_end: assert property (
    (busy_q && cur_q.write && last && !start) |=> pins_q.data_oe_b)
    else $error("data still driven after write cycle");
  // a write never pulls the read strobe
  a_wr_no_read: assert property (
    (busy_q && cur_q.write) |-> pins_q.read_strobe_n)
    else $error("read strobe low during write");

endmodule // smw_top

// ==== include/smw_pkg.sv ====
// shared constants and carrier types for the static memory waveform generator
package smw_pkg;

  localparam int          NUM_CS           = 4;
  localparam int          CNT_W            = 10;
  localparam int          ADDR_W           = 24;
  localparam int          DATA_W           = 8;

  // register map, byte addresses, one block of four words per chip select
  localparam logic [7:0]  OFS_SETUP        = 8'h00;
  localparam logic [7:0]  OFS_PULSE        = 8'h04;
  localparam logic [7:0]  OFS_CYCLE        = 8'h08;
  localparam logic [7:0]  OFS_MODE         = 8'h0c;
  localparam logic [7:0]  CS_STRIDE        = 8'h10;
  localparam logic [7:0]  CS_BLOCK_END     = 8'h40;
  localparam logic [7:0]  OFS_PROT_MODE    = 8'he4;
  localparam logic [7:0]  OFS_PROT_STATUS  = 8'he8;

  // field positions inside setup and pulse words
  localparam int          POS_WR_STROBE    = 0;
  localparam int          POS_CS_WRITE     = 8;
  localparam int          POS_RD_STROBE    = 16;
  localparam int          POS_CS_READ      = 24;
  // field positions inside cycle word
  localparam int          POS_WR_CYCLE     = 0;
  localparam int          POS_RD_CYCLE     = 16;
  // mode and protection bits
  localparam int          POS_READ_MODE    = 0;
  localparam int          POS_WRITE_MODE   = 1;
  localparam int          POS_PROT_EN      = 0;
  localparam int          POS_PROT_FLAG    = 0;
  localparam int          POS_PROT_SRC     = 8;

  // reset values
  localparam logic [31:0] RST_SETUP        = 32'h01010101;
  localparam logic [31:0] RST_PULSE        = 32'h01010101;
  localparam logic [31:0] RST_CYCLE        = 32'h00030003;
  localparam logic [31:0] RST_MODE         = 32'h00000003;

  // request from the on-chip master
  typedef struct packed {
    logic              write;
    logic [1:0]        cs;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } smw_req_t;

  // external memory pins, enable active low
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [NUM_CS-1:0] chip_select_n;
    logic              read_strobe_n;
    logic              write_strobe_n;
    logic [DATA_W-1:0] dout;
    logic              data_oe_b;
  } smw_pins_t;

endpackage

// ==== test/smw_mem_model.sv ====
// behavioural external byte memory answering the waveform generator pins
`timescale 1ns/1ps
module smw_mem_model (
  input  wire logic               clk_i,
  input  wire smw_pkg::smw_pins_t pins_i,
  input  wire logic               lcd_i,
  input  wire logic [3:0]         lat_i,
  output logic      [7:0]         data_o
);
  logic [7:0] mem_q [256];
  logic [7:0] last_q = 8'h00;
  logic [3:0] low_q  = 4'h0;
  logic       sel;
  logic       rd_act;

  // lcd parts answer while selected, sram parts while the read strobe is low
  assign sel    = ~&pins_i.chip_select_n;
  assign rd_act = pins_i.data_oe_b & (lcd_i ? sel : ~pins_i.read_strobe_n);
  // a slow part needs lat_i cycles; off the bus the line toggles so stale data never matches
  assign data_o = (rd_act && low_q >= lat_i) ? mem_q[pins_i.addr[7:0]] : ~last_q;

  // access age counter and last driven value
  always @(posedge clk_i) begin
    last_q <= data_o;
    low_q  <= !rd_act ? 4'h0 : (low_q == 4'hf) ? low_q : low_q + 4'h1;
  end

  // sram stores on the strobe rise; an undriven bus lands as garbage
  always @(posedge pins_i.write_strobe_n)
    if (!lcd_i) mem_q[pins_i.addr[7:0]] = pins_i.data_oe_b ? ~pins_i.dout : pins_i.dout;

  // lcd stores on the chip select rise, only while the bus is driven
  always @(negedge sel)
    if (lcd_i && !pins_i.data_oe_b) mem_q[pins_i.addr[7:0]] = pins_i.dout;
endmodule // smw_mem_model

// ==== test/tb_top.sv ====
// self-checking bench for the static memory waveform generator
`timescale 1ns/1ps
module tb_top;
  logic               clk_i       = 1'b0;
  logic               rst_b_i     = 1'b0;
  logic               hsel_i      = 1'b0;
  logic [31:0]        haddr_i     = 32'h0;
  logic [1:0]         htrans_i    = 2'b00;
  logic               hwrite_i    = 1'b0;
  logic [2:0]         hsize_i     = 3'b010;
  logic [31:0]        hwdata_i    = 32'h0;
  logic               hready_i;
  logic [31:0]        hrdata_o;
  logic               hreadyout_o;
  logic               hresp_o;
  logic               req_valid_i = 1'b0;
  smw_pkg::smw_req_t  req_i       = '0;
  logic               req_ready_o;
  logic               rsp_valid_o;
  logic [7:0]         rsp_data_o;
  smw_pkg::smw_pins_t pins_o;
  logic [7:0]         data_i;
  logic               lcd         = 1'b0;
  logic [3:0]         lat         = 4'h0;
  int                 n_fail      = 0;
  int                 compares    = 0;
  int                 cyc         = 0;

  assign hready_i = hreadyout_o;  // the only slave drives the bus ready

  always #12.5 clk_i = ~clk_i;

  smw_top u_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .pins_o(pins_o), .data_i(data_i)
  );

  smw_mem_model u_mem (
    .clk_i(clk_i), .pins_i(pins_o), .lcd_i(lcd), .lat_i(lat), .data_o(data_i)
  );

  task automatic wrap_up();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // cut a hang short far beyond the thousand or so cycles the tests need
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask

  // one single word transfer: address phase, then data phase, each held until ready
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge clk_i);
    hsel_i   <= 1'b1;
    haddr_i  <= a;
    htrans_i <= 2'b10;
    hwrite_i <= w;
    hsize_i  <= 3'b010;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    hsel_i   <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= d;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    rd = hrdata_o;
  endtask

  task automatic wreg(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rreg(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk($sformatf("reg %h", a[7:0]), e & m, x & m);
    chk("response", 32'h0, {31'h0, hresp_o});
  endtask

  // one memory access; a read expects data d, capture seen at e_lat, cycle length e_len
  task automatic acc(input logic w, input logic [1:0] cs, input logic [7:0] a,
                     input logic [7:0] d, input int e_lat, input int e_len);
    int         lat_n = 0;
    int         len_n = 0;
    logic [7:0] got   = 8'h00;
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_i       <= '{w, cs, {16'h0, a}, d};
    do @(negedge clk_i); while (req_ready_o !== 1'b1);
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    for (int k = 1; k < 2000 && (len_n == 0 || (!w && lat_n == 0)); k++) begin
      @(negedge clk_i);
      if (rsp_valid_o === 1'b1 && lat_n == 0) begin
        lat_n = k;
        got   = rsp_data_o;
      end
      if (req_ready_o === 1'b1 && len_n == 0) len_n = k;
    end
    chk("cycle length", e_len, len_n);
    if (!w) begin
      chk("capture time", e_lat, lat_n);
      chk("read data", {24'h0, d}, {24'h0, got});
    end
  endtask

  initial begin
    logic [31:0] exp3 [4];
    int          k;
    exp3 = '{32'h00210101, 32'h01400101, 32'h01000003, 32'h00000003};
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    for (int n = 0; n < 4; n++) begin
      rreg(n * 16, 32'h01010101, 32'hffffffff);
      rreg(n * 16 + 4, 32'h01010101, 32'hffffffff);
      rreg(n * 16 + 8, 32'h00030003, 32'hffffffff);
      rreg(n * 16 + 12, 32'h3, 32'h3);
    end
    wreg(32'h80, 32'hffffffff);
    rreg(32'h80, 32'h0, 32'hffffffff);
    $display("test reset_values done");
    acc(1'b1, 2'd0, 8'h21, 8'h5a, 0, 3);
    acc(1'b0, 2'd0, 8'h21, 8'h5a, 3, 3);
    $display("test default_access done");
    // every pulse at least one, setup plus pulse within its cycle
    wreg(32'h10, 32'h01020301);
    wreg(32'h14, 32'h05030102);
    wreg(32'h18, 32'h00090005);
    rreg(32'h10, 32'h01020301, 32'hffffffff);
    rreg(32'h00, 32'h01010101, 32'hffffffff);
    acc(1'b1, 2'd1, 8'h42, 8'ha5, 0, 5);
    acc(1'b0, 2'd1, 8'h42, 8'ha5, 6, 9);
    $display("test strobe_mode done");
    lcd <= 1'b1;
    wreg(32'h20, 32'h02010201);
    wreg(32'h24, 32'h02060201);
    wreg(32'h28, 32'h00080006);
    wreg(32'h2c, 32'h0);
    acc(1'b1, 2'd2, 8'h63, 8'h3c, 0, 6);
    acc(1'b0, 2'd2, 8'h63, 8'h3c, 5, 8);
    lcd <= 1'b0;
    $display("test select_mode done");
    lat <= 4'h8;
    for (int i = 0; i < 3; i++)
      wreg(32'h30 + 4 * i, exp3[i]);
    acc(1'b1, 2'd3, 8'h84, 8'hc3, 0, 3);
    acc(1'b0, 2'd3, 8'h84, 8'hc3, 386, 512);
    lat <= 4'h0;
    $display("test long_fields done");
    wreg(32'h00, 32'h00000101);
    wreg(32'h04, 32'h02020101);
    wreg(32'h08, 32'h00020003);
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_i       <= '{1'b0, 2'd0, 24'h21, 8'h00};
    do @(negedge clk_i); while (req_ready_o !== 1'b1);
    k = 0;
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        @(posedge clk_i);
        req_valid_i <= 1'b0;
      end
      @(negedge clk_i);
      if (pins_o.read_strobe_n === 1'b0 && pins_o.chip_select_n[0] === 1'b0) k++;
    end
    chk("gapless strobe", 4, k);
    repeat (4) @(posedge clk_i);
    $display("test back_to_back done");
    wreg(32'he4, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wreg(32'h30 + 4 * i, 32'h0);
      rreg(32'he8, ((32'h30 + 4 * i) << 8) | 32'h1, 32'h0000ff01);
      rreg(32'he8, 32'h0, 32'h1);
      rreg(32'h30 + 4 * i, exp3[i], 32'hffffffff);
    end
    wreg(32'h00, 32'h0);
    rreg(32'he8, 32'h00000001, 32'h0000ff01);
    rreg(32'h00, 32'h00000101, 32'hffffffff);
    wreg(32'he4, 32'h0);
    wreg(32'h3c, 32'h1);
    rreg(32'h3c, 32'h1, 32'h3);
    rreg(32'he8, 32'h0, 32'h1);
    $display("test protection done");
    wrap_up();
  end
endmodule // tb_top
